// ===== verilog/dds_ctrl.sv
`timescale 1ns/1ps
module dds_ctrl
  import dds_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic output_load_n,
  input wire logic register_clear_n,
  input wire logic clear_level,
  output logic [DATA_W-1:0] input_a,
  output logic [DATA_W-1:0] input_b,
  output logic [DATA_W-1:0] dac_a,
  output logic [DATA_W-1:0] dac_b,
  output logic frame_overflow
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins come from the host's domain; two flops each before use
  logic [SYNC_STAGES-1:0] s_cs, s_clk, s_din, s_ld, s_clr, s_lvl;
  logic prev_cs, prev_sclk;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_cs <= '1;
      s_clk <= '0;
      s_din <= '0;
      s_ld <= '1;
      s_clr <= '1;
      s_lvl <= '0;
    end
    else
    begin
      s_cs <= {s_cs[0], chip_sel_n};
      s_clk <= {s_clk[0], serial_clk};
      s_din <= {s_din[0], serial_in};
      s_ld <= {s_ld[0], output_load_n};
      s_clr <= {s_clr[0], register_clear_n};
      s_lvl <= {s_lvl[0], clear_level};
    end
  end

  // Edge history taken only from the second stage
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      prev_cs <= 1'b1;
      prev_sclk <= 1'b0;
    end
    else
    begin
      prev_cs <= s_cs[1];
      prev_sclk <= s_clk[1];
    end
  end

  logic cs_n, sclk, din, ld_n, clr_n, lvl;
  assign cs_n = s_cs[1];
  assign sclk = s_clk[1];
  assign din = s_din[1];
  assign ld_n = s_ld[1];
  assign clr_n = s_clr[1];
  assign lvl = s_lvl[1];

  logic sclk_rise, cs_rise;
  assign sclk_rise = sclk && !prev_sclk;
  assign cs_rise = cs_n && !prev_cs;

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  logic [FRAME_W-1:0] shift_reg;
  // Only the newest frame-width bits survive; older ones fall off the top
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_reg <= '0;
    end
    else if (!cs_n && sclk_rise && ld_n && clr_n)
    begin
      shift_reg <= {shift_reg[FRAME_W-2:0], din}; // (R01) (R07)
    end
  end

  // ----------------------------------------
  // Frame capture into staging FIFO
  // ----------------------------------------
  logic fifo_in_ready, fifo_out_valid;
  logic [FRAME_W-1:0] fifo_out_data;
  logic push_frame;
  // Capture on select rise; serial clock must be low then
  assign push_frame = cs_rise && !sclk && clr_n; // (R02) (R09)

  dds_fifo #(
    .WIDTH(FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(push_frame),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg),
    .out_valid(fifo_out_valid),
    .out_ready(clr_n),
    .out_data(fifo_out_data)
  );

  // Drain stalls during clear so queued frames survive it
  // Sticky flag: a frame arrived with the FIFO full and was lost
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      frame_overflow <= 1'b0;
    end
    else if (push_frame && !fifo_in_ready)
    begin
      frame_overflow <= 1'b1;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [1:0] decode_target(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      ADDR_NONE: decode_target = 2'h0;
      ADDR_A: decode_target = 2'h1;
      ADDR_B: decode_target = 2'h2;
      ADDR_AB: decode_target = 2'h3;
    endcase
  endfunction : decode_target

  logic target_sel_hi, target_sel_lo;
  logic [DATA_W-1:0] frame_data;
  logic [1:0] hit;
  logic drain;
  assign {target_sel_hi, target_sel_lo} = fifo_out_data[FRAME_W-1 -: ADDR_W];
  assign frame_data = fifo_out_data[DATA_W-1:0];
  assign hit = decode_target({target_sel_hi, target_sel_lo}); // (R08)
  assign drain = fifo_out_valid && clr_n;

  logic [DATA_W-1:0] clear_code;
  assign clear_code = lvl ? HALF_CODE : ZERO_CODE; // (R05) (R06)

  // ----------------------------------------
  // Input registers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      input_a <= ZERO_CODE; // (R10)
      input_b <= ZERO_CODE;
    end
    else if (!clr_n)
    begin
      input_a <= clear_code; // (R05) (R06)
      input_b <= clear_code;
    end
    else if (drain)
    begin
      if (hit[0])
      begin
        input_a <= frame_data; // (R02) (R08)
      end
      if (hit[1])
      begin
        input_b <= frame_data; // (R02) (R08)
      end
    end
  end

  // ----------------------------------------
  // Output (DAC) registers
  // ----------------------------------------
  // Transparency is emulated by copying every cycle while load is low and select is high
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dac_a <= ZERO_CODE; // (R10)
      dac_b <= ZERO_CODE;
    end
    else if (!clr_n)
    begin
      dac_a <= clear_code; // (R05) (R06)
      dac_b <= clear_code;
    end
    else if (!ld_n && cs_n)
    begin
      dac_a <= input_a; // (R03)
      dac_b <= input_b;
    end
    // Otherwise held (R04)
  end
endmodule : dds_ctrl

// ===== verilog/dds_pkg.sv
// Behaviour
// (R01) Chip select low: serial clock edges shift data; the code shifts on rising edges, and only while load and clear are high
// (R02) Chip select rise loads addressed input registers
// (R03) Load low, select high: outputs follow inputs
// (R04) Load high: output registers hold their value
// (R05) Clear with level low forces all-zero code
// (R06) Clear with level high forces half-scale code
// (R07) Frame is address plus data, MSB first
// (R08) Address 00 none, 01 A, 10 B, 11 both
// (R09) Host holds serial clock still during load
// (R10) Power-up leaves all registers at zero
// (R11) Data width parameter sets frame and half-scale
package dds_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 2;
  localparam int FRAME_W = DATA_W + ADDR_W; // (R07) (R11)
  localparam logic [DATA_W-1:0] ZERO_CODE = '0; // (R05) (R10)
  localparam logic [DATA_W-1:0] HALF_CODE = {1'b1, {(DATA_W-1){1'b0}}}; // (R06) (R11)
  // Address decode codes
  localparam logic [ADDR_W-1:0] ADDR_NONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_A = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_B = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_AB = 2'h3;
  // Staging FIFO between frame capture and input registers
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;
endpackage : dds_pkg

// ===== verilog/dds_fifo.sv
`timescale 1ns/1ps
module dds_fifo
  import dds_pkg::*;
#(
  parameter int WIDTH = FRAME_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dds_fifo

// ===== sim/dds_ctrl_properties.sv
`timescale 1ns/1ps
module dds_ctrl_properties
  import dds_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic output_load_n,
  input wire logic register_clear_n,
  input wire logic clear_level,
  input wire logic [DATA_W-1:0] input_a,
  input wire logic [DATA_W-1:0] input_b,
  input wire logic [DATA_W-1:0] dac_a,
  input wire logic [DATA_W-1:0] dac_b,
  input wire logic frame_overflow
);
  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Windows outlast the pin sync latency so no pin race trips them
  sequence clr_s(lv);
    (!register_clear_n && clear_level == lv) [*6];
  endsequence
  sequence quiet_s(c);
    (c && register_clear_n) [*8];
  endsequence
  wire logic [4*DATA_W-1:0] regs = {input_a, input_b, dac_a, dac_b};
  clear_zero_a: assert property (clr_s(1'b0) |-> regs == '0)
    else $error("clear to zero missed");
  clear_half_a: assert property (clr_s(1'b1) |-> regs == {4{HALF_CODE}})
    else $error("clear to half scale missed");
  reset_zero_a: assert property ($past(sys_rst) |-> regs == '0)
    else $error("registers not zero after reset");
  input_hold_a: assert property (quiet_s(chip_sel_n) |=> $stable({input_a, input_b}))
    else $error("input register moved without a frame");
  select_low_hold_a: assert property (quiet_s(!chip_sel_n) |=> $stable({dac_a, dac_b}))
    else $error("output moved during a frame");
  load_hold_a: assert property (quiet_s(output_load_n) |=> $stable({dac_a, dac_b}))
    else $error("output moved while load high");
  output_follow_a: assert property (quiet_s(!output_load_n && chip_sel_n) |->
    {dac_a, dac_b} == $past({input_a, input_b})) else $error("output not following input");
  overflow_sticky_a: assert property (frame_overflow |=> frame_overflow)
    else $error("overflow flag dropped");
endmodule : dds_ctrl_properties

bind dds_ctrl dds_ctrl_properties dds_ctrl_properties_inst (.*);

// ===== sim/dds_host.sv
`timescale 1ns/1ps
module dds_host
(
  input wire logic clock,
  output logic chip_sel_n,
  output logic serial_clk,
  output logic serial_in
);
  // Idle: deselected, clock parked low
  initial
  begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // Each level held 4 clocks, two above what the two-stage sync needs
  task automatic send(input logic [31:0] w, input int n);
    chip_sel_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in <= w[i];
      repeat (4) @(posedge clock);
      serial_clk <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    chip_sel_n <= 1'b1;
    serial_in <= ~serial_in; // Released line must not show a stale bit
    repeat (4) @(posedge clock);
  endtask : send
endmodule : dds_host

// ===== sim/tb_dds_ctrl.sv
`timescale 1ns/1ps
module tb_dds_ctrl
  import dds_pkg::*;
;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic output_load_n = 1'b1;
  logic register_clear_n = 1'b1;
  logic clear_level = 1'b0;
  logic chip_sel_n, serial_clk, serial_in, frame_overflow;
  logic [DATA_W-1:0] input_a, input_b, dac_a, dac_b, exp_a, exp_b;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  dds_ctrl dds_ctrl_inst (
    .clock(clock),
    .sys_rst(sys_rst),
    .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk),
    .serial_in(serial_in),
    .output_load_n(output_load_n),
    .register_clear_n(register_clear_n),
    .clear_level(clear_level),
    .input_a(input_a),
    .input_b(input_b),
    .dac_a(dac_a),
    .dac_b(dac_b),
    .frame_overflow(frame_overflow)
  );
  dds_host dds_host_inst (
    .clock(clock),
    .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk),
    .serial_in(serial_in)
  );
  // Clock, 4 ns period
  initial
  begin
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    n_compared++;
    if (got !== want)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  // Samples at the falling edge, away from register updates
  task automatic chk_all(input logic [DATA_W-1:0] ia, ib, da, db);
    @(negedge clock);
    chk(input_a, ia);
    chk(input_b, ib);
    chk(dac_a, da);
    chk(dac_b, db);
    @(posedge clock);
  endtask : chk_all
  // Every address code, each frame led by 4 surplus bits
  task automatic t_frames();
    logic [DATA_W-1:0] d;
    for (int a = 0; a < 4; a++)
    begin
      d = DATA_W'(16'h1357 * (a + 1));
      dds_host_inst.send({10'h155, ADDR_W'(a), d}, FRAME_W + 4);
      if (a[0]) exp_a = d;
      if (a[1]) exp_b = d;
      repeat (12) @(posedge clock);
      chk_all(exp_a, exp_b, ZERO_CODE, ZERO_CODE);
    end
  endtask : t_frames
  // Transparent while low, then held against a new frame
  task automatic t_load();
    output_load_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk_all(exp_a, exp_b, exp_a, exp_b);
    output_load_n <= 1'b1;
    repeat (8) @(posedge clock);
    dds_host_inst.send({ADDR_AB, 16'hFFFF}, FRAME_W);
    repeat (12) @(posedge clock);
    chk_all(16'hFFFF, 16'hFFFF, exp_a, exp_b);
  endtask : t_load
  // Mid-run reset zeroes everything, then the first frame still lands
  task automatic t_reset();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    exp_a = ZERO_CODE;
    exp_b = ZERO_CODE;
    repeat (4) @(posedge clock);
    chk_all(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE);
    dds_host_inst.send({ADDR_A, 16'hA5C3}, FRAME_W);
    exp_a = 16'hA5C3;
    repeat (12) @(posedge clock);
    chk_all(exp_a, exp_b, ZERO_CODE, ZERO_CODE);
  endtask : t_reset
  // Both clear levels
  task automatic t_clear();
    logic [DATA_W-1:0] e;
    for (int lv = 0; lv < 2; lv++)
    begin
      clear_level <= lv[0];
      register_clear_n <= 1'b0;
      e = lv ? HALF_CODE : ZERO_CODE;
      repeat (10) @(posedge clock);
      chk_all(e, e, e, e);
      register_clear_n <= 1'b1;
      repeat (8) @(posedge clock);
    end
  endtask : t_clear
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    exp_a = ZERO_CODE;
    exp_b = ZERO_CODE;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk_all(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE);
    t_frames();
    t_load();
    t_reset();
    t_clear();
    chk(DATA_W'(frame_overflow), ZERO_CODE);
    report_and_stop();
  end
endmodule : tb_dds_ctrl
